// *** verilog/sos_defines.svh ***
// Purpose: constants for the option strap decoder of the drive unit
// Assumes: straps are active-low pins (0 = shorted), 20 MHz clock
// Notes:   pin pairs of the option strap block map to bits 0..7
`ifndef SOS_DEFINES_SVH
`define SOS_DEFINES_SVH

// ==========================================================
// strap bit positions
`define SOS_B_LEVEL      0
`define SOS_B_SDP        1
`define SOS_B_RNDRPT     2
`define SOS_B_PERDEF     3
`define SOS_B_MOTOR      4
`define SOS_B_PARITY     5
`define SOS_B_RATE       6
`define SOS_B_SYNCREQ    7

// ==========================================================
// inquiry fields
`define SOS_VER_SCSI2    3'h2
`define SOS_VER_LEGACY   3'h1
`define SOS_FMT_SCSI2    4'h2
`define SOS_FMT_LEGACY   4'h1
`define SOS_FEAT_BYTE7   8'h00

// ==========================================================
// sync period factors (units of 4 ns): larger = slower
// 4.8 MB/s ~ 208 ns = 52, 2.67 MB/s ~ 375 ns = 94 (rounded up)
`define SOS_PER_FAST     8'h34
`define SOS_PER_SLOW     8'h5e
`define SOS_OFFSET_MAX   8'h0f

// ==========================================================
// mode page lengths, sense lengths
`define SOS_ALL_PAGES    6'h3f
`define SOS_P1_LEN_S2    8'h0a
`define SOS_P1_LEN_LG    8'h06
`define SOS_P2_LEN_S2    8'h0a
`define SOS_P2_LEN_LG    8'h0a
`define SOS_P4_LEN_S2    8'h16
`define SOS_P4_LEN_LG    8'h12
`define SOS_P7_LEN       8'h0a
`define SOS_P8_LEN       8'h0a
`define SOS_SENSE_ZERO   8'h04
`define SOS_KEY_RECOV    4'h1

// ==========================================================
// timing
`define SOS_SETTLE_NS    1000
`define SOS_CLK_NS       50
`define SOS_SETTLE_CYC   ((`SOS_SETTLE_NS + `SOS_CLK_NS - 1) / `SOS_CLK_NS)

`endif

// *** verilog/sos_pkg.sv ***
// Purpose: types for the option strap decoder
// Assumes: no defines included; the state width is fixed in the enum
// Notes:   sdtr negotiation states
package sos_pkg;
  typedef enum logic [1:0] {
    SOS_IDLE  = 2'b00,
    SOS_SEND  = 2'b01,
    SOS_WAIT  = 2'b11,
    SOS_AGREE = 2'b10
  } sos_neg_t;
endpackage

// *** verilog/sos_strap_latch.sv ***
// Purpose: sample option straps through two flops, latch once after the settle time following reset release
// Assumes: strap pins are asynchronous and static during operation
// Notes:   latched value held until the next reset
`timescale 1ns/100ps
`include "sos_defines.svh"
module sos_strap_latch
  import sos_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] strap_n,
  output logic      [7:0] shorted,
  output logic            valid
);
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [4:0] settle_r;

  // ==========================================================
  // synchroniser; first stage read only by the second
  always_ff @(posedge clk) begin
    sync1_r <= strap_n;
    sync2_r <= sync1_r;
  end

  // wait for pins to settle after reset, then capture once
  always_ff @(posedge clk) begin
    if (reset) begin
      settle_r <= 5'h00;
      valid    <= 1'b0;
      shorted  <= 8'h00;
    end else if (!valid) begin
      settle_r <= settle_r + 5'h01;
      if (settle_r == 5'(`SOS_SETTLE_CYC)) begin
        valid   <= 1'b1;
        shorted <= ~sync2_r;
      end
    end
  end

  a_strap_hold: assert property (@(posedge clk) disable iff (reset)
    valid |=> (valid && $stable(shorted)))
    else $error("straps changed while held");
endmodule

// *** verilog/sos_option_decoder.sv ***
// Purpose: apply option straps to inquiry, sense, parity, motor, sdtr
// Assumes: command logic around gives decoded requests as pulses
// Notes:   shorted-strap effects wait for ready; before it every strap reads as open
`timescale 1ns/100ps
`include "sos_defines.svh"
module sos_option_decoder
  import sos_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] strap_n,
  output logic            ready,
  output logic            level_scsi2,
  output logic            per_default,
  // inquiry
  output logic      [2:0] inq_version,
  output logic      [3:0] inq_format,
  output logic      [7:0] inq_features,
  output logic            vpd_valid,
  // disconnect after data
  input  wire logic       disc_req,
  input  wire logic       disc_after_data,
  output logic            send_save_ptr,
  output logic            disc_go,
  // mode select rounding
  input  wire logic       mselect_done,
  input  wire logic       mselect_rounded,
  output logic            report_check,
  output logic      [3:0] report_key,
  // motor
  input  wire logic       start_unit_cmd,
  input  wire logic       stop_unit_cmd,
  output logic            spindle_on,
  // parity
  input  wire logic       rx_strobe,
  input  wire logic       rx_parity_ok,
  output logic            parity_error,
  // sdtr
  input  wire logic       want_sync,
  input  wire logic       init_sdtr,
  input  wire logic [7:0] init_period,
  input  wire logic [7:0] init_offset,
  output logic            tgt_sdtr_send,
  output logic      [7:0] sync_period,
  output logic      [7:0] sync_offset,
  output logic            sync_mode,
  // mode sense and request sense
  input  wire logic       msense_req,
  input  wire logic [5:0] msense_page,
  output logic      [4:0] page_mask,
  output logic      [7:0] page_len,
  output logic            page_valid,
  input  wire logic       rsense_req,
  input  wire logic [7:0] rsense_alloc,
  output logic      [7:0] sense_len,
  output logic            verify_use_p1
);
  logic [7:0] sh;
  sos_neg_t   neg_r;
  sos_neg_t   neg_nxt;
  logic [7:0] cap_per;
  logic [7:0] ag_per_nxt;
  logic [7:0] ag_off_nxt;

  // ==========================================================
  // strap capture
  sos_strap_latch u_latch (
    .clk     (clk),
    .reset   (reset),
    .strap_n (strap_n),
    .shorted (sh),
    .valid   (ready)
  );

  assign level_scsi2 = sh[`SOS_B_LEVEL];
  assign per_default = ~sh[`SOS_B_PERDEF]; // open reads as one

  // ==========================================================
  // inquiry fields by level
  always_ff @(posedge clk) begin
    if (reset) begin
      inq_version  <= 3'h0;
      inq_format   <= 4'h0;
      inq_features <= 8'h00;
      vpd_valid    <= 1'b0;
    end else if (level_scsi2) begin
      inq_version  <= `SOS_VER_SCSI2;
      inq_format   <= `SOS_FMT_SCSI2;
      inq_features <= `SOS_FEAT_BYTE7;
      vpd_valid    <= ready;
    end else begin
      inq_version  <= `SOS_VER_LEGACY;
      inq_format   <= `SOS_FMT_LEGACY;
      inq_features <= 8'h00;
      vpd_valid    <= 1'b0;
    end
  end

  // ==========================================================
  // disconnect: optional save pointer message, flagged on the same edge as it
  always_ff @(posedge clk) begin
    if (reset) begin
      send_save_ptr <= 1'b0;
      disc_go       <= 1'b0;
    end else begin
      send_save_ptr <= disc_req && disc_after_data
                       && sh[`SOS_B_SDP];
      disc_go       <= disc_req;
    end
  end

  // ==========================================================
  // rounding report; open strap posts recovered error
  always_ff @(posedge clk) begin
    if (reset) begin
      report_check <= 1'b0;
      report_key   <= 4'h0;
    end else if (mselect_done) begin
      report_check <= mselect_rounded && !sh[`SOS_B_RNDRPT];
      report_key   <= (mselect_rounded && !sh[`SOS_B_RNDRPT])
                      ? `SOS_KEY_RECOV : 4'h0;
    end else begin
      report_check <= 1'b0;
    end
  end

  // ==========================================================
  // spindle: auto start only once straps are known
  always_ff @(posedge clk) begin
    if (reset) begin
      spindle_on <= 1'b0;
    end else if (start_unit_cmd) begin
      spindle_on <= 1'b1;
    end else if (stop_unit_cmd) begin
      spindle_on <= 1'b0;
    end else if (ready && $rose(ready) && sh[`SOS_B_MOTOR]) begin
      spindle_on <= 1'b1;
    end
  end

  // ==========================================================
  // parity check gated by strap
  always_ff @(posedge clk) begin
    if (reset) begin
      parity_error <= 1'b0;
    end else begin
      parity_error <= rx_strobe && !rx_parity_ok
                      && sh[`SOS_B_PARITY];
    end
  end

  // ==========================================================
  // sdtr negotiation; async path never sees these straps
  assign cap_per = sh[`SOS_B_RATE] ? `SOS_PER_FAST : `SOS_PER_SLOW;

  always_comb begin
    neg_nxt    = neg_r;
    ag_per_nxt = sync_period;
    ag_off_nxt = sync_offset;
    // slowest of both sides; never faster than initiator asked
    if (init_sdtr) begin
      ag_per_nxt = (init_period > cap_per) ? init_period : cap_per;
      ag_off_nxt = (init_offset > `SOS_OFFSET_MAX)
                   ? `SOS_OFFSET_MAX : init_offset;
    end
    unique case (neg_r)
      SOS_IDLE: begin
        if (init_sdtr) begin
          neg_nxt = SOS_AGREE;
        end else if (want_sync && ready && sh[`SOS_B_SYNCREQ]) begin
          neg_nxt = SOS_SEND;
        end
      end
      SOS_SEND: begin
        neg_nxt = SOS_WAIT;
      end
      SOS_WAIT: begin
        if (init_sdtr) begin
          neg_nxt = SOS_AGREE;
        end
      end
      SOS_AGREE: begin
        neg_nxt = SOS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      neg_r <= SOS_IDLE;
    end else begin
      neg_r <= neg_nxt;
    end
  end

  assign tgt_sdtr_send = (neg_r == SOS_SEND);

  // agreed parameters held until next exchange or reset
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_period <= 8'h00;
      sync_offset <= 8'h00;
      sync_mode   <= 1'b0;
    end else if (init_sdtr) begin
      sync_period <= ag_per_nxt;
      sync_offset <= ag_off_nxt;
      sync_mode   <= (ag_off_nxt != 8'h00);
    end
  end

  // ==========================================================
  // mode sense pages; bits: 0=p1,1=p2,2=p4,3=p7,4=p8
  always_ff @(posedge clk) begin
    if (reset) begin
      page_mask  <= 5'h00;
      page_len   <= 8'h00;
      page_valid <= 1'b0;
    end else begin
      page_valid <= msense_req;
      if (msense_req) begin
        page_len <= 8'h00;
        unique case (msense_page)
          `SOS_ALL_PAGES: begin
            page_mask <= level_scsi2 ? 5'h1f : 5'h07;
          end
          6'h01: begin
            page_mask <= 5'h01;
            page_len  <= level_scsi2 ? `SOS_P1_LEN_S2 : `SOS_P1_LEN_LG;
          end
          6'h02: begin
            page_mask <= 5'h02;
            page_len  <= level_scsi2 ? `SOS_P2_LEN_S2 : `SOS_P2_LEN_LG;
          end
          6'h04: begin
            page_mask <= 5'h04;
            page_len  <= level_scsi2 ? `SOS_P4_LEN_S2 : `SOS_P4_LEN_LG;
          end
          6'h07: begin
            page_mask <= 5'h08;
            page_len  <= `SOS_P7_LEN;
          end
          6'h08: begin
            page_mask <= 5'h10;
            page_len  <= `SOS_P8_LEN;
          end
          default: begin
            page_mask <= 5'h00;        // unsupported page
          end
        endcase
      end
    end
  end

  // ==========================================================
  // request sense length and verify recovery source
  always_ff @(posedge clk) begin
    if (reset) begin
      sense_len     <= 8'h00;
      verify_use_p1 <= 1'b0;
    end else begin
      verify_use_p1 <= !level_scsi2 && ready;
      if (rsense_req) begin
        sense_len <= (rsense_alloc == 8'h00 && !level_scsi2)
                     ? `SOS_SENSE_ZERO : rsense_alloc;
      end
    end
  end

  // ==========================================================
  // checks
  a_inq_version: assert property (@(posedge clk) disable iff (reset)
    ready |=> (inq_version == ($past(level_scsi2) ? 3'h2 : 3'h1)))
    else $error("inquiry version wrong for level");
  a_save_ptr: assert property (@(posedge clk) disable iff (reset)
    send_save_ptr |-> $past(sh[1]) && $past(disc_after_data))
    else $error("save pointer sent while strap open");
  a_round_rpt: assert property (@(posedge clk) disable iff (reset)
    report_check |-> !sh[2] && report_key == 4'h1)
    else $error("rounding reported while strap shorted");
  a_motor_wait: assert property (@(posedge clk) disable iff (reset)
    ($rose(spindle_on) && !sh[4]) |-> $past(start_unit_cmd))
    else $error("spindle started without command");
  a_parity_gate: assert property (@(posedge clk) disable iff (reset)
    parity_error |-> sh[5] && $past(rx_strobe))
    else $error("parity flagged while check off");
  a_rate_cap: assert property (@(posedge clk) disable iff (reset)
    (sync_mode && !sh[6]) |-> sync_period >= 8'h5e)
    else $error("sync rate above slow cap");
  a_no_own_sdtr: assert property (@(posedge clk) disable iff (reset)
    !sh[7] |-> !tgt_sdtr_send)
    else $error("own sdtr sent while disabled");
  a_answer_init: assert property (@(posedge clk) disable iff (reset)
    (init_sdtr && neg_r == SOS_IDLE) |=> neg_r == SOS_AGREE ##1
      neg_r == SOS_IDLE)
    else $error("initiator sdtr not answered");
  a_init_bound: assert property (@(posedge clk) disable iff (reset)
    init_sdtr |=> sync_period >= $past(init_period))
    else $error("agreed rate above initiator");
  a_legacy_all: assert property (@(posedge clk) disable iff (reset)
    (msense_req && msense_page == 6'h3f && !level_scsi2)
      |=> page_mask == 5'h07)
    else $error("legacy all-pages returned 7 or 8");
  a_sense_four: assert property (@(posedge clk) disable iff (reset)
    (rsense_req && rsense_alloc == 8'h00 && !level_scsi2)
      |=> sense_len == 8'h04)
    else $error("legacy zero allocation not four bytes");
endmodule

// *** testbench/sos_init_model.sv ***
// Purpose: initiator side of the sdtr exchange for the strap decoder
// Assumes: offers are single-cycle pulses taken on the rising edge
// Notes:   lines show the inverse of the last offer between offers
`timescale 1ns/100ps
module sos_init_model (
  input  wire logic       clk,
  output logic            init_sdtr,
  output logic      [7:0] init_period,
  output logic      [7:0] init_offset
);
  // ==========================================================
  // idle levels, no offer pending
  initial begin
    init_sdtr   = 1'b0;
    init_period = 8'hff;
    init_offset = 8'h00;
  end

  // one offer: the caller picks values that its bus can carry
  // stale values are inverted so a late sample cannot pass by luck
  task automatic offer(input logic [7:0] error_report_default, input logic [7:0] ofs);
    @(posedge clk);
    #1 init_sdtr = 1'b1;
    init_period = error_report_default;
    init_offset = ofs;
    @(posedge clk);
    #1 init_sdtr = 1'b0;
    init_period = ~error_report_default;
    init_offset = ~ofs;
  endtask
endmodule

// *** testbench/sos_target_option_straps_bench.sv ***
// Purpose: self-checking bench for the option strap decoder
// Assumes: straps 0 = shorted, one strap set per reset
// Notes:   all-shorted and all-open sets cover both sides of each strap
`timescale 1ns/100ps
`include "sos_defines.svh"
module sos_target_option_straps_bench;
  import sos_pkg::*;
  // ==========================================================
  // signals
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] strap_n = 8'h00;
  logic       ready, level_scsi2, per_default, vpd_valid, verify_use_p1;
  logic [2:0] inq_version;
  logic [3:0] inq_format, report_key;
  logic [7:0] inq_features, sync_period, sync_offset, page_len, sense_len;
  logic       disc_req = 0, disc_after_data = 0, send_save_ptr, disc_go;
  logic       mselect_done = 0, mselect_rounded = 0, report_check;
  logic       start_unit_cmd = 0, stop_unit_cmd = 0, spindle_on;
  logic       rx_strobe = 0, rx_parity_ok = 1, parity_error;
  logic       want_sync = 0, init_sdtr, tgt_sdtr_send, sync_mode;
  logic [7:0] init_period, init_offset;
  logic       msense_req = 0, page_valid, rsense_req = 0;
  logic [5:0] msense_page = 6'h00;
  logic [4:0] page_mask;
  logic [7:0] rsense_alloc = 8'h00;
  int         err_total = 0;
  int         check_count = 0;

  // 20 MHz
  always #25 clk = ~clk;

  sos_option_decoder DUT (.clk(clk), .reset(reset), .strap_n(strap_n),
    .ready(ready), .level_scsi2(level_scsi2), .per_default(per_default),
    .inq_version(inq_version), .inq_format(inq_format),
    .inq_features(inq_features), .vpd_valid(vpd_valid),
    .disc_req(disc_req), .disc_after_data(disc_after_data),
    .send_save_ptr(send_save_ptr), .disc_go(disc_go),
    .mselect_done(mselect_done), .mselect_rounded(mselect_rounded),
    .report_check(report_check), .report_key(report_key),
    .start_unit_cmd(start_unit_cmd), .stop_unit_cmd(stop_unit_cmd),
    .spindle_on(spindle_on), .rx_strobe(rx_strobe),
    .rx_parity_ok(rx_parity_ok), .parity_error(parity_error),
    .want_sync(want_sync), .init_sdtr(init_sdtr),
    .init_period(init_period), .init_offset(init_offset),
    .tgt_sdtr_send(tgt_sdtr_send), .sync_period(sync_period),
    .sync_offset(sync_offset), .sync_mode(sync_mode),
    .msense_req(msense_req), .msense_page(msense_page),
    .page_mask(page_mask), .page_len(page_len), .page_valid(page_valid),
    .rsense_req(rsense_req), .rsense_alloc(rsense_alloc),
    .sense_len(sense_len), .verify_use_p1(verify_use_p1));

  sos_init_model INIT (.clk(clk), .init_sdtr(init_sdtr),
    .init_period(init_period), .init_offset(init_offset));

  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // new strap set only counts after a reset
  task automatic boot(input logic [7:0] s);
    int n;
    strap_n = s;
    reset = 1'b1;
    repeat (5) @(posedge clk);
    #1 reset = 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk); // inquiry fields follow ready by one edge
    #1 chk(8'(ready), 8'h01, "ready");
  endtask

  // ==========================================================
  // scenarios, lg = legacy set (all straps open)
  task automatic t_inquiry(input logic lg);
    chk(8'(inq_version), lg ? 8'h01 : 8'h02, "version");
    chk(8'(inq_format), lg ? 8'h01 : 8'h02, "format");
    chk(8'(vpd_valid), 8'(!lg), "vpd");
    chk(inq_features, lg ? 8'h00 : `SOS_FEAT_BYTE7, "byte 7");
    chk(8'(per_default), 8'(lg), "per default");
  endtask

  task automatic t_disc(input logic lg);
    disc_req = 1'b1;
    disc_after_data = 1'b1;
    @(posedge clk);
    #1 disc_req = 1'b0;
    disc_after_data = 1'b0;
    chk(8'(send_save_ptr), 8'(!lg), "save pointer");
    chk(8'(disc_go), 8'h01, "disconnect");
  endtask

  task automatic t_round(input logic lg);
    mselect_done = 1'b1;
    mselect_rounded = 1'b1;
    @(posedge clk);
    #1 mselect_done = 1'b0;
    mselect_rounded = 1'b0;
    chk(8'(report_check), 8'(lg), "round report");
    if (lg) chk(8'(report_key), 8'(`SOS_KEY_RECOV), "key");
  endtask

  task automatic t_motor(input logic lg);
    chk(8'(spindle_on), 8'(!lg), "power-on spin");
    start_unit_cmd = 1'b1;
    @(posedge clk);
    #1 start_unit_cmd = 1'b0;
    stop_unit_cmd = 1'b1;
    chk(8'(spindle_on), 8'h01, "start unit");
    @(posedge clk);
    #1 stop_unit_cmd = 1'b0;
    chk(8'(spindle_on), 8'h00, "stop unit");
  endtask

  task automatic t_parity(input logic lg);
    rx_strobe = 1'b1;
    rx_parity_ok = 1'b0;
    @(posedge clk);
    #1 rx_parity_ok = 1'b1;
    chk(8'(parity_error), 8'(!lg), "bad parity");
    @(posedge clk);
    #1 rx_strobe = 1'b0;
    chk(8'(parity_error), 8'h00, "good parity");
  endtask

  task automatic t_sdtr(input logic lg);
    int n;
    logic seen;
    seen = 1'b0;
    want_sync = 1'b1;
    for (n = 0; n < 6; n++) begin
      @(posedge clk);
      #1 seen |= tgt_sdtr_send;
    end
    want_sync = 1'b0;
    chk(8'(seen), 8'(!lg), "own sdtr");
    INIT.offer(8'h20, 8'h20);
    chk(sync_period, lg ? `SOS_PER_SLOW : `SOS_PER_FAST, "cap");
    chk(sync_offset, `SOS_OFFSET_MAX, "offset");
    chk(8'(sync_mode), 8'h01, "sync on");
    INIT.offer(8'h80, 8'h00);
    chk(sync_period, 8'h80, "declared rate");
    chk(8'(sync_mode), 8'h00, "async");
  endtask

  task automatic page(input logic [5:0] p);
    // one idle edge so back-to-back calls never re-raise the strobe
    @(posedge clk);
    #1 msense_page = p;
    msense_req = 1'b1;
    @(posedge clk);
    #1 msense_req = 1'b0;
    chk(8'(page_valid), 8'h01, "page valid");
  endtask

  task automatic t_pages(input logic lg);
    page(6'h3f);
    chk(8'($countones(page_mask)), lg ? 8'h03 : 8'h05, "all");
    page(6'h01);
    chk(page_len, lg ? `SOS_P1_LEN_LG : `SOS_P1_LEN_S2, "p1");
    page(6'h04);
    chk(page_len, lg ? `SOS_P4_LEN_LG : `SOS_P4_LEN_S2, "p4");
    page(6'h07);
    chk(page_len, `SOS_P7_LEN, "p7");
    rsense_req = 1'b1;
    @(posedge clk);
    #1 rsense_req = 1'b0;
    chk(sense_len, lg ? `SOS_SENSE_ZERO : 8'h00, "sense 0");
    chk(8'(verify_use_p1), 8'(lg), "verify");
  endtask

  // straps moved after capture must change nothing
  task automatic t_hold;
    strap_n = 8'h00;
    repeat (30) @(posedge clk);
    #1 chk(8'(level_scsi2), 8'h00, "held level");
    chk(8'(inq_version), 8'h01, "held version");
    t_disc(1'b1);
  endtask

  task automatic run(input logic lg);
    t_inquiry(lg);
    t_disc(lg);
    t_round(lg);
    t_motor(lg);
    t_parity(lg);
    t_sdtr(lg);
    t_pages(lg);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    boot(8'h00);
    run(1'b0);
    boot(8'hff);
    run(1'b1);
    t_hold;
    final_report;
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    final_report;
  end
endmodule
